/* bench/samap_checker.sv */
// Alarm mapper checker
`timescale 1ns/1ps
`default_nettype none
module samap_checker (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic srq_ack,
  input wire logic srq,
  input wire logic query_valid,
  input wire logic query_last,
  input wire logic [31:0] alarm_lines
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_new; |(alarm_lines & ~$past(alarm_lines)); endsequence
  property p_set; s_new |-> srq; endproperty
  a_set: assert property (p_set) else $error("srq late");
  property p_why; $rose(srq) |-> s_new; endproperty
  a_why: assert property (p_why) else $error("srq spurious");
  property p_keep; $fell(srq) |-> $past(srq_ack); endproperty
  a_keep: assert property (p_keep) else $error("srq dropped");
  property p_clr; $past(srq_ack) && $stable(alarm_lines) |-> !srq; endproperty
  a_clr: assert property (p_clr) else $error("srq kept");
  property p_beg; $rose(query_valid) |-> !query_last [*3] ##1 query_last; endproperty
  a_beg: assert property (p_beg) else $error("byte count");
  property p_run; query_valid && !query_last |=> query_valid; endproperty
  a_run: assert property (p_run) else $error("byte gap");
  property p_last; query_last |-> query_valid; endproperty
  a_last: assert property (p_last) else $error("last alone");
  property p_end; query_last |=> !query_valid; endproperty
  a_end: assert property (p_end) else $error("extra byte");
  c_new: cover property (s_new);
  c_img: cover property (query_last);
  c_ack: cover property (srq && srq_ack);
endmodule : samap_checker
bind samap_top samap_checker i_samap_checker (.*);
`default_nettype wire

/* bench/samap_host.sv */
// Host model for the alarm mapper
`timescale 1ns/1ps
`default_nettype none
module samap_host (
  input wire logic sys_clk,
  input wire logic srq,
  input wire logic query_last,
  output logic srq_ack,
  output logic query_req
);
  // Ack each request, promptly or late, then fetch one image
  initial begin
    {srq_ack, query_req} = 2'b00;
    forever begin
      @(posedge sys_clk iff srq === 1'b1);
      repeat ($urandom_range(2)) @(posedge sys_clk);
      {srq_ack, query_req} <= 2'b11;
      @(posedge sys_clk);
      {srq_ack, query_req} <= 2'b00;
      @(posedge query_last);
    end
  end
endmodule : samap_host
`default_nettype wire

/* bench/testbench.sv */
// Alarm mapper bench
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk, resetn, map_write, sp_write, sample_valid, sample_from_slave, sp_low_en;
  logic sp_high_en, srq_ack, query_req, srq, query_valid, query_last;
  logic [6:0] map_first, map_last, sp_chan, sample_chan;
  logic [5:0] map_output;
  logic [15:0] sp_low, sp_high, sample_value;
  logic [7:0] query_byte, exp_q[$];
  logic [31:0] alarm_lines;
  int miscompares = 0, comparisons = 0;
  samap_top i_samap_top (.sys_clk(sys_clk), .resetn(resetn), .map_write(map_write),
    .map_first(map_first), .map_last(map_last), .map_output(map_output),
    .sp_write(sp_write), .sp_chan(sp_chan), .sp_low(sp_low), .sp_high(sp_high),
    .sp_low_en(sp_low_en), .sp_high_en(sp_high_en), .sample_valid(sample_valid),
    .sample_chan(sample_chan), .sample_from_slave(sample_from_slave),
    .sample_value(sample_value), .srq_ack(srq_ack), .query_req(query_req), .srq(srq),
    .query_valid(query_valid), .query_byte(query_byte), .query_last(query_last),
    .alarm_lines(alarm_lines));
  samap_host i_samap_host (.sys_clk(sys_clk), .srq(srq), .query_last(query_last),
    .srq_ack(srq_ack), .query_req(query_req));
  always #10 sys_clk = ~sys_clk;
  task automatic check(input logic [31:0] got, exp);
    comparisons++;
    miscompares += (got !== exp);
    if (got !== exp) $display("MISMATCH %0t compare", $time);
  endtask : check
  task automatic close_out;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  // One scan sample; note the image bytes if a query follows
  task automatic step(input logic [6:0] c, input logic s, input logic [15:0] v,
                      input logic [31:0] e, input int q);
    @(posedge sys_clk);
    {sample_valid, sample_chan, sample_from_slave, sample_value} <= {1'b1, c, s, v};
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    for (int i = 0; i < q; i++) exp_q.push_back(e[8 * i +: 8]);
    #1 check(alarm_lines, e);
    repeat (12) @(posedge sys_clk);
  endtask : step
  // Each query byte against the oldest note
  always @(negedge sys_clk) if (query_valid === 1'b1)
    check(query_byte, exp_q.size() ? exp_q.pop_front() : 32'h100);
  initial begin
    #60000 check(32'h0, 32'h1);
    close_out();
  end
  // Reset, map 0..3 to output 32 arming 0 and 3, then scan
  initial begin
    {sys_clk, resetn, map_write, sp_write, sample_valid, sample_from_slave} = '0;
    {map_first, map_last, sp_chan, sample_chan, map_output, sample_value} = '0;
    {sp_low_en, sp_high_en, sp_low, sp_high} = {2'b11, 16'hff9c, 16'h0064};
    void'($urandom(32'he18903da));
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    {map_write, sp_write, map_last, map_output} <= {2'b11, 7'h03, 6'h20};
    @(posedge sys_clk);
    {map_write, sp_chan} <= {1'b0, 7'h03};
    @(posedge sys_clk);
    sp_write <= 1'b0;
    step(7'h00, 1'b0, 16'h0065, 32'h8000_0000, 4);
    step(7'h01, 1'b0, 16'h01f4, 32'h8000_0000, 0);
    step(7'h03, 1'b1, 16'hff9b, 32'h8000_0000, 0);
    step(7'h00, 1'b0, 16'hff9c, 32'h8000_0000, 0);
    step(7'h03, 1'b0, 16'h0000, 32'h0, 0);
    repeat (3) step(7'h00, 1'b0, 16'($urandom_range(200)) - 16'h0064, 32'h0, 0);
    check(srq, 32'h0);
    check(exp_q.size(), 32'h0);
    close_out();
  end
endmodule : testbench
`default_nettype wire

/* src/samap_chan_eval.sv */
// Per-sample setpoint compare for one scanned channel
`timescale 1ns/1ps
`default_nettype none
module samap_chan_eval #(
  parameter int SAMPLE_W = 16
) (
  input wire logic signed [SAMPLE_W-1:0] sample,
  input wire logic signed [SAMPLE_W-1:0] low_setpoint,
  input wire logic signed [SAMPLE_W-1:0] high_setpoint,
  input wire logic low_enable,
  input wire logic high_enable,
  output logic in_alarm
);
  // Beyond either enabled setpoint at the sampling instant
  assign in_alarm = (high_enable && (sample > high_setpoint)) ||
                    (low_enable && (sample < low_setpoint));
endmodule : samap_chan_eval
`default_nettype wire

/* src/samap_map.svh */
// Constants for the scan alarm output mapper
`ifndef SAMAP_MAP_SVH
`define SAMAP_MAP_SVH
`define SAMAP_NUM_OUTPUTS 32
`define SAMAP_NUM_CHANNELS 128
`define SAMAP_CHAN_W 7
`define SAMAP_OUT_W 6
`define SAMAP_SAMPLE_W 16
`define SAMAP_IMAGE_BYTES 4
`define SAMAP_OUT_NONE 6'h00
`endif

/* src/samap_pkg.sv */
// Types for the scan alarm output mapper
package samap_pkg;
  typedef enum logic [1:0] {
    SAMAP_IDLE = 2'b00,
    SAMAP_SEND = 2'b01
  } samap_qstate_t;
endpackage : samap_pkg

/* src/samap_top.sv */
// Alarm output mapper: scan evaluation, alarm lines, service request, query image
// Notes for users of this block
// - A sample updates only the alarm state of the channel it names; all other
//   channels hold the state taken at their own last scan.
// - Lines follow the channel alarms one clock after the sample edge, and the
//   service request rises in the same cycle as the line that caused it.
// - The service request is set only by a line going from off to on; a line
//   that stays on does not raise it again after an acknowledge.
// - An acknowledge in the cycle of a new line loses: the request stays set so
//   that the host never misses a fresh alarm.
// - A query captures the lines in the cycle it is taken; alarms that arrive
//   while the four bytes go out show up only in the next query.
// - A query that arrives while bytes are still going out is dropped.
// - Map changes act on the stored channel alarms and do not rescan; a new
//   mapping shows on the lines two cycles after the write.
// - Output number 0 leaves a channel unassigned; it then drives no line.
// - The slave flag on a sample is not used by this block; the alarm path
//   treats master and slave samples alike.
`timescale 1ns/1ps
`default_nettype none
`include "samap_map.svh"
module samap_top
  import samap_pkg::*;
#(
  parameter int NUM_CHANNELS = `SAMAP_NUM_CHANNELS,
  parameter int CHAN_W = `SAMAP_CHAN_W,
  parameter int SAMPLE_W = `SAMAP_SAMPLE_W
) (
  input wire logic sys_clk,
  input wire logic resetn,
  // Channel map write from host: range first..last to output number
  input wire logic map_write,
  input wire logic [CHAN_W-1:0] map_first,
  input wire logic [CHAN_W-1:0] map_last,
  input wire logic [`SAMAP_OUT_W-1:0] map_output,
  // Setpoint config per channel
  input wire logic sp_write,
  input wire logic [CHAN_W-1:0] sp_chan,
  input wire logic signed [SAMPLE_W-1:0] sp_low,
  input wire logic signed [SAMPLE_W-1:0] sp_high,
  input wire logic sp_low_en,
  input wire logic sp_high_en,
  // Scan sample stream, from master or slave units
  input wire logic sample_valid,
  input wire logic [CHAN_W-1:0] sample_chan,
  input wire logic sample_from_slave,
  input wire logic signed [SAMPLE_W-1:0] sample_value,
  // Host service request and query
  input wire logic srq_ack,
  input wire logic query_req,
  output logic srq,
  output logic query_valid,
  output logic [7:0] query_byte,
  output logic query_last,
  // Back panel alarm lines
  output logic [`SAMAP_NUM_OUTPUTS-1:0] alarm_lines
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [NUM_CHANNELS-1:0] chan_alarm;
    logic [NUM_CHANNELS-1:0][`SAMAP_OUT_W-1:0] chan_map;
    logic [NUM_CHANNELS-1:0][SAMPLE_W-1:0] low_sp;
    logic [NUM_CHANNELS-1:0][SAMPLE_W-1:0] high_sp;
    logic [NUM_CHANNELS-1:0] low_en;
    logic [NUM_CHANNELS-1:0] high_en;
    logic [`SAMAP_NUM_OUTPUTS-1:0] lines;
    logic srq;
    samap_qstate_t qstate;
    logic [1:0] byte_idx;
    logic [`SAMAP_NUM_OUTPUTS-1:0] image;
    logic qvalid;
    logic [7:0] qbyte;
    logic qlast;
  } samap_state_t;

  samap_state_t s_q;
  samap_state_t s_d;
  logic eval_alarm;
  logic [NUM_CHANNELS-1:0] alarm_next;
  logic [`SAMAP_NUM_OUTPUTS-1:0] lines_next;

  // ****************************************
  // Setpoint compare for the channel now scanned
  // ****************************************
  samap_chan_eval #(
    .SAMPLE_W(SAMPLE_W)
  ) u_eval (
    .sample(sample_value),
    .low_setpoint(s_q.low_sp[sample_chan]),
    .high_setpoint(s_q.high_sp[sample_chan]),
    .low_enable(s_q.low_en[sample_chan]),
    .high_enable(s_q.high_en[sample_chan]),
    .in_alarm(eval_alarm)
  );

  // ****************************************
  // Channel alarm update on a scan sample
  // ****************************************
  // Only the scanned channel moves; kept apart from the state copy so the
  // line OR below never reads a value that this same logic is still building
  always_comb begin
    alarm_next = s_q.chan_alarm;
    if (sample_valid) begin
      alarm_next[sample_chan] = eval_alarm;
    end
  end

  // ****************************************
  // Line OR from channel alarms
  // ****************************************
  // Each line gathers every channel mapped to its number
  for (genvar o = 0; o < `SAMAP_NUM_OUTPUTS; o++) begin : g_line
    logic [NUM_CHANNELS-1:0] hit;
    for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_ch
      assign hit[c] = alarm_next[c] &&
                      (s_q.chan_map[c] == `SAMAP_OUT_W'(o + 1));
    end
    assign lines_next[o] = |hit;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    // Map write over an inclusive channel range
    if (map_write) begin
      for (int c = 0; c < NUM_CHANNELS; c++) begin
        if (CHAN_W'(c) >= map_first && CHAN_W'(c) <= map_last) begin
          s_d.chan_map[c] = map_output;
        end
      end
    end
    if (sp_write) begin
      s_d.low_sp[sp_chan] = sp_low;
      s_d.high_sp[sp_chan] = sp_high;
      s_d.low_en[sp_chan] = sp_low_en;
      s_d.high_en[sp_chan] = sp_high_en;
    end
    // Alarm state only moves on a scan sample; master and slave alike
    s_d.chan_alarm = alarm_next;
    s_d.lines = lines_next;
    // New alarm raises service request; set wins over ack
    if (srq_ack) begin
      s_d.srq = 1'b0;
    end
    if (|(lines_next & ~s_q.lines)) begin
      s_d.srq = 1'b1;
    end
    // Query answer: four bytes, A07-A00 first
    s_d.qvalid = 1'b0;
    s_d.qlast = 1'b0;
    unique case (s_q.qstate)
      SAMAP_IDLE: begin
        if (query_req) begin
          s_d.image = s_q.lines;
          s_d.byte_idx = 2'h0;
          s_d.qstate = SAMAP_SEND;
        end
      end
      SAMAP_SEND: begin
        s_d.qvalid = 1'b1;
        s_d.qbyte = s_q.image[s_q.byte_idx*8 +: 8];
        s_d.qlast = (s_q.byte_idx == 2'h3);
        s_d.byte_idx = s_q.byte_idx + 2'h1;
        if (s_q.byte_idx == 2'h3) begin
          s_d.qstate = SAMAP_IDLE;
        end
      end
      default: begin
        s_d.qstate = SAMAP_IDLE;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  // One register bank for all state; reset clears maps and disables every
  // setpoint, so no line can come up before the host has configured it
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Outputs straight from flip-flops
  assign alarm_lines = s_q.lines;
  assign srq = s_q.srq;
  assign query_valid = s_q.qvalid;
  assign query_byte = s_q.qbyte;
  assign query_last = s_q.qlast;

endmodule : samap_top
`default_nettype wire
